// *** hdl/switch_ctrl_map.svh ***
`ifndef SWITCH_CTRL_MAP_SVH
`define SWITCH_CTRL_MAP_SVH

// Serial frame layout
`define FRAME_BITS        16
`define FRAME_MSB         15
`define FRAME_WE_BIT      15
`define FRAME_CTRL_HI     14
`define FRAME_CTRL_LO     8
`define FRAME_DRIVE_HI    7
`define FRAME_DRIVE_LO    0

// Control/status register fields
`define CTRL_FAULT_BIT    6
`define CTRL_SLEEP_BIT    5
`define CTRL_FMODE_BIT    4
`define CTRL_VPPOFF_BIT   3
`define CTRL_PUMP_BIT     1
`define CTRL_FIELD_MSB    6

// Switch-drive register fields
`define DRIVE_HV_HI       3
`define DRIVE_HV_LO       0

// Reset values
`define DRIVE_RESET       8'h00
`define CTRL_RESET        7'h00
`define FRAME_RESET       16'h0000
`define HV_OFF            4'h0

// Level sampled on the mode and strap pins for each port form
`define MODE_SERIAL_LVL   1'b0
`define STRAP_PAR_LVL     1'b0

// Host clock ceiling, in MHz, and the system clock rate
`define SCK_MAX_MHZ       33
`define SYS_CLK_MHZ       10

// Synchronised input vector width
`define SYNC_WIDTH        12

`endif

// *** hdl/switch_ctrl_pkg.sv ***
package switch_ctrl_pkg;
   typedef logic [7:0]  reg8_type;
   typedef logic [6:0]  ctrl_field_type;
   typedef logic [15:0] frame_type;
   typedef logic [3:0]  hv_type;
   typedef enum logic {PORT_SERIAL, PORT_PARALLEL} port_mode_type;
endpackage : switch_ctrl_pkg

// *** hdl/input_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,  // System clock
   input  wire logic             rst_n,    // Synchronous reset, active low
   input  wire logic [WIDTH-1:0] async_in, // Pins from outside the clock domain
   output logic      [WIDTH-1:0] sync_out  // Two-flop synchronised copy
);
   logic [WIDTH-1:0] stage1_q;

   // First stage feeds only the second stage to keep metastability contained
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stage1_q <= '0;
         sync_out <= '0;
      end else begin
         stage1_q <= async_in;
         sync_out <= stage1_q;
      end
   end
endmodule : input_sync
`default_nettype wire

// *** hdl/switch_driver_control_port.sv ***
// What this block does
// - Mode pin low selects serial port
// - Parallel mode uses port pins, select as fourth
// - Serial clock well below sys_clk, short of its ceiling
// - Select fall presents shift MSB on output
// - Sample serial input on clock rise
// - Shift next bit out on clock fall
// - Register image returns while new frame enters
// - Select rise copies frame when write permitted
// - Frame: permit, seven control, eight drive bits
// - Permit zero frame only reads registers
// - Reset clears both registers
// - Drive bits 3..0 set outputs D..A
// - Control bit 1 enables charge pump
// - Control bit 5 selects sleep
// - Control bit 4 low enables fault shutdown
// - Control bit 3 disables rail comparator
// - Fault bit sticks until written zero
// - Control bits 2 and 0 unused
// - Serial mode ignores pump and fault pins
// - Parallel inputs 1..4 drive outputs A..D
// - Pump pin enables pump in parallel mode
// - Fault shutdown forces outputs low, pump off
// - Fault output low while logic undervoltage, or rail undervoltage with comparator on, present
`include "switch_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module switch_driver_control_port (
   input  wire logic                      sys_clk,            // System clock, 10 MHz
   input  wire logic                      rst_n,              // Synchronous reset, active low
   input  wire logic                      mode_select,        // Port form select pin
   input  wire logic                      polarity_strap,     // Parallel polarity strap pin
   input  wire logic                      sck,                // Serial clock pin
   input  wire logic                      sdi,                // Serial data in pin
   input  wire logic                      port_select_n,      // Select pin, ctrl 4 in parallel
   input  wire logic                      ctrl_in_1,          // Parallel control input 1
   input  wire logic                      ctrl_in_2,          // Parallel control input 2
   input  wire logic                      ctrl_in_3,          // Parallel control input 3
   input  wire logic                      pump_enable_pin,    // Pump enable pin
   input  wire logic                      fault_shutdown_pin, // Fault shutdown mode pin
   input  wire logic                      logic_uv_fault,     // Logic supply undervoltage
   input  wire logic                      rail_uv_fault,      // High-voltage rail undervoltage
   output logic                           sdo,                // Serial data out
   output logic                           sdo_oe,             // Serial out drive enable
   input  wire logic                      fault_out_n_in,     // Fault pin level seen
   output logic                           fault_out_n_out,    // Fault pin driven level
   output logic                           fault_out_n_oe,     // Fault pin pull-down enable
   output logic                           hv_out_a,           // High-voltage output A
   output logic                           hv_out_b,           // High-voltage output B
   output logic                           hv_out_c,           // High-voltage output C
   output logic                           hv_out_d,           // High-voltage output D
   output logic                           pump_on,            // Charge pump run
   output logic                           analog_sleep,       // All analog circuits off
   output logic                           rail_uv_check_off,  // Rail comparator disabled
   output switch_ctrl_pkg::reg8_type      switch_drive_reg,   // Switch-drive register
   output switch_ctrl_pkg::reg8_type      supervisory_ctrl_reg, // Control/status register
   output switch_ctrl_pkg::port_mode_type port_mode           // Active port form
);
   import switch_ctrl_pkg::*;

   logic [`SYNC_WIDTH-1:0] pins_raw;
   logic [`SYNC_WIDTH-1:0] pins_s;
   logic sck_s, sdi_s, sel_s, sel_n_s, mode_s, strap_s;
   logic ctrl_in_1_s, ctrl_in_2_s, ctrl_in_3_s, pump_pin_s, fmode_pin_s, vdd_uv_s, vpp_uv_s;
   logic sck_prev_q, sel_n_prev_q;
   logic sck_rise, sck_fall, sel_fall, sel_rise, serial, parallel_ok;
   frame_type shift_q;
   reg8_type drive_q;
   ctrl_field_type ctrl_q;
   logic fault_now, shut_enabled, pump_req, trip_q;
   hv_type hv_q;

   // The reflected level is not needed: the pull-down alone decides the pin
   logic unused_in;
   assign unused_in = fault_out_n_in;

   // Select is synchronised inverted, so the all-zero reset of the
   // synchroniser reads as deselected and no false select edge follows reset
   assign pins_raw = {rail_uv_fault, logic_uv_fault,
                      fault_shutdown_pin, pump_enable_pin, ctrl_in_3, ctrl_in_2,
                      ctrl_in_1, polarity_strap, mode_select, !port_select_n, sdi, sck};

   input_sync #(.WIDTH(`SYNC_WIDTH)) u_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (pins_raw),
      .sync_out (pins_s)
   );

   assign {vpp_uv_s, vdd_uv_s, fmode_pin_s, pump_pin_s, ctrl_in_3_s, ctrl_in_2_s,
           ctrl_in_1_s, strap_s, mode_s, sel_s, sdi_s, sck_s} = pins_s;
   assign sel_n_s = !sel_s;

   // Readback image of the registers; permit bit always reads zero
   function automatic frame_type reg_image(input ctrl_field_type c, input reg8_type d);
      reg_image = {1'b0, c, d};
   endfunction : reg_image

   assign serial      = (mode_s == `MODE_SERIAL_LVL);
   assign parallel_ok = !serial && (strap_s == `STRAP_PAR_LVL);
   assign port_mode   = serial ? PORT_SERIAL : PORT_PARALLEL;

   // Edges are found by sampling; the host clock must stay well below the
   // system clock, so the serial ceiling is only met when sys_clk is fast
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sck_prev_q   <= 1'b0;
         sel_n_prev_q <= 1'b1;
      end else begin
         sck_prev_q   <= sck_s;
         sel_n_prev_q <= sel_n_s;
      end
   end

   assign sck_rise = serial && !sel_n_s && sck_s && !sck_prev_q;
   assign sck_fall = serial && !sel_n_s && !sck_s && sck_prev_q;
   assign sel_fall = serial && !sel_n_s && sel_n_prev_q;
   assign sel_rise = serial && sel_n_s && !sel_n_prev_q;

   // Select rise reloads the shift path with the register image; within one
   // select a chained device passes earlier bits downstream while taking new ones
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         shift_q <= `FRAME_RESET;
      end else if (sck_rise) begin
         shift_q <= {shift_q[`FRAME_MSB-1:0], sdi_s};
      end else if (sel_rise) begin
         shift_q <= reg_image(ctrl_next(shift_q), drive_next(shift_q));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sdo <= 1'b0;
      end else if (sel_fall) begin
         sdo <= shift_q[`FRAME_MSB];
      end else if (sck_fall) begin
         sdo <= shift_q[`FRAME_MSB];
      end
   end

   assign sdo_oe = serial && !sel_n_s;

   // Fault detect: rail comparator is gated by its disable in either form
   assign rail_uv_check_off = serial ? ctrl_q[`CTRL_VPPOFF_BIT] : !pump_pin_s;
   assign fault_now = vdd_uv_s || (vpp_uv_s && !rail_uv_check_off);

   function automatic logic frame_writes(input frame_type f);
      frame_writes = f[`FRAME_WE_BIT];
   endfunction : frame_writes

   function automatic reg8_type drive_next(input frame_type f);
      drive_next = frame_writes(f) ? f[`FRAME_DRIVE_HI:`FRAME_DRIVE_LO] : drive_q;
   endfunction : drive_next

   // Fault bit: a write can only clear it, and a live fault wins the clear
   function automatic ctrl_field_type ctrl_next(input frame_type f);
      ctrl_field_type c;
      c = frame_writes(f) ? f[`FRAME_CTRL_HI:`FRAME_CTRL_LO] : ctrl_q;
      c[`CTRL_FAULT_BIT] = (c[`CTRL_FAULT_BIT] && ctrl_q[`CTRL_FAULT_BIT]) || fault_now;
      ctrl_next = c;
   endfunction : ctrl_next

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         drive_q <= `DRIVE_RESET;
      end else if (sel_rise && frame_writes(shift_q)) begin
         drive_q <= shift_q[`FRAME_DRIVE_HI:`FRAME_DRIVE_LO];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_q <= `CTRL_RESET;
      end else if (sel_rise) begin
         ctrl_q <= ctrl_next(shift_q);
      end else if (fault_now) begin
         ctrl_q[`CTRL_FAULT_BIT] <= 1'b1;
      end
   end

   assign switch_drive_reg     = drive_q;
   assign supervisory_ctrl_reg = {1'b0, ctrl_q};

   // Pins replaced by register bits in serial mode; bits 2 and 0 read by nobody
   assign pump_req     = serial ? ctrl_q[`CTRL_PUMP_BIT] : pump_pin_s;
   assign shut_enabled = serial ? !ctrl_q[`CTRL_FMODE_BIT] : !fmode_pin_s;

   // Trip holds until the pump request drops with no fault under enabled shutdown, so the host
   // must toggle the enable to restart
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         trip_q <= 1'b0;
      end else if (fault_now && shut_enabled) begin
         trip_q <= 1'b1;
      end else if (!pump_req) begin
         trip_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hv_q <= `HV_OFF;
      end else if (trip_q || (fault_now && shut_enabled)) begin
         hv_q <= `HV_OFF;
      end else if (serial) begin
         hv_q <= drive_q[`DRIVE_HV_HI:`DRIVE_HV_LO];
      end else if (parallel_ok) begin
         hv_q <= {sel_n_s, ctrl_in_3_s, ctrl_in_2_s, ctrl_in_1_s};
      end else begin
         hv_q <= `HV_OFF;
      end
   end

   assign {hv_out_d, hv_out_c, hv_out_b, hv_out_a} = hv_q;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pump_on      <= 1'b0;
         analog_sleep <= 1'b0;
      end else begin
         analog_sleep <= serial && ctrl_q[`CTRL_SLEEP_BIT];
         pump_on      <= pump_req && !trip_q && !(fault_now && shut_enabled)
                         && !(serial && ctrl_q[`CTRL_SLEEP_BIT]);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         fault_out_n_oe <= 1'b0;
      end else begin
         fault_out_n_oe <= fault_now;
      end
   end

   assign fault_out_n_out = 1'b0;
endmodule : switch_driver_control_port
`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic sys_clk,       // Pacing clock
   input  wire logic sdo,           // Device output
   output var logic  sck,           // Link clock
   output var logic  sdi,           // Data to device
   output var logic  port_select_n  // Select
);
   import switch_ctrl_pkg::*;
   initial begin
      sck = 1'b0;
      sdi = 1'b0;
      port_select_n = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wait_clk
   // Four system clocks a half period: 400 ns, far below the ceiling
   // Thirty-two bits under one select stand in for an upstream chained device
   task automatic frame(input logic [31:0] tx, input int bits, output logic [31:0] rx);
      rx = '0;
      port_select_n = 1'b0;
      wait_clk(8);
      for (int i = bits - 1; i >= 0; i--) begin
         sdi = tx[i];
         wait_clk(4);
         sck = 1'b1;
         wait_clk(4);
         rx[i] = sdo;
         sck = 1'b0;
      end
      wait_clk(4);
      sdi = 1'b0;
      port_select_n = 1'b1;
      wait_clk(8); // Clock idles low while deselected
   endtask : frame
endmodule : host_model
`default_nettype wire

// *** tb/switch_driver_control_port_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module switch_driver_control_port_chk (
   input wire logic sys_clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic mode_select, // Mode pin
   input wire logic polarity_strap, // Strap
   input wire logic sck, // Link clock
   input wire logic port_select_n, // Select
   input wire logic ctrl_in_1, // Control 1
   input wire logic ctrl_in_2, // Control 2
   input wire logic ctrl_in_3, // Control 3
   input wire logic fault_shutdown_pin, // Fault mode pin
   input wire logic logic_uv_fault, // Logic fault
   input wire logic rail_uv_fault, // Rail fault
   input wire logic sdo, // Serial out
   input wire logic fault_out_n_oe, // Fault pull-down
   input wire logic hv_out_a, // Output A
   input wire logic hv_out_b, // Output B
   input wire logic hv_out_c, // Output C
   input wire logic hv_out_d, // Output D
   input wire logic pump_on, // Pump
   input wire logic analog_sleep, // Sleep
   input wire logic rail_uv_check_off, // Comparator off
   input wire switch_ctrl_pkg::reg8_type switch_drive_reg, // Drive reg
   input wire switch_ctrl_pkg::reg8_type supervisory_ctrl_reg, // Control reg
   input wire switch_ctrl_pkg::port_mode_type port_mode // Port form
);
   import switch_ctrl_pkg::*;
   logic [3:0] hv;
   logic [3:0] fall_age;
   logic       ser;
   assign hv = {hv_out_d, hv_out_c, hv_out_b, hv_out_a};
   assign ser = port_mode == PORT_SERIAL;
   // Cycles since the last falling link clock or select, saturating
   always_ff @(posedge sys_clk) begin
      if (!rst_n || $fell(sck) || $fell(port_select_n)) begin
         fall_age <= 4'h0;
      end else if (fall_age != 4'hf) begin
         fall_age <= fall_age + 4'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   mode_pick_a: assert property ($stable(mode_select) [*4] |-> ser == !mode_select)
      else $error("port form does not follow mode pin");
   par_follow_a: assert property ((!ser && !polarity_strap && fault_shutdown_pin &&
      $stable({port_select_n, ctrl_in_3, ctrl_in_2, ctrl_in_1})) [*5]
      |-> hv == {port_select_n, ctrl_in_3, ctrl_in_2, ctrl_in_1}) else $error("parallel outputs wrong");
   strap_off_a: assert property ((!ser && polarity_strap) [*5] |-> hv == 4'h0)
      else $error("outputs on with strap high");
   sdo_timing_a: assert property ($changed(sdo) |-> fall_age <= 4'h6)
      else $error("serial out moved without a falling edge");
   frame_hold_a: assert property ((ser && !port_select_n) [*6] |=> $stable(switch_drive_reg) &&
      (supervisory_ctrl_reg[6] || !$past(supervisory_ctrl_reg[6]))) else $error("register changed mid frame");
   pump_bit_a: assert property ((ser && !supervisory_ctrl_reg[1]) [*2] |-> !pump_on)
      else $error("pump on with enable bit clear");
   sleep_bit_a: assert property ((ser && $stable(supervisory_ctrl_reg)) [*2]
      |-> analog_sleep == supervisory_ctrl_reg[5]) else $error("sleep output wrong");
   rail_off_a: assert property (ser |-> rail_uv_check_off == supervisory_ctrl_reg[3])
      else $error("rail comparator control wrong");
   fault_pull_a: assert property (logic_uv_fault [*5] |-> fault_out_n_oe)
      else $error("fault pin not pulled low");
   fault_free_a: assert property ((!logic_uv_fault && !rail_uv_fault) [*5] |-> !fault_out_n_oe)
      else $error("fault pin low without fault");
   trip_off_a: assert property ((ser && !supervisory_ctrl_reg[4] && logic_uv_fault) [*5]
      |-> hv == 4'h0 && !pump_on) else $error("no shutdown on fault");
endmodule : switch_driver_control_port_chk
bind switch_driver_control_port switch_driver_control_port_chk chk (.sys_clk(sys_clk),
   .rst_n(rst_n), .mode_select(mode_select), .polarity_strap(polarity_strap), .sck(sck),
   .port_select_n(port_select_n), .ctrl_in_1(ctrl_in_1), .ctrl_in_2(ctrl_in_2),
   .ctrl_in_3(ctrl_in_3), .fault_shutdown_pin(fault_shutdown_pin), .logic_uv_fault(logic_uv_fault),
   .rail_uv_fault(rail_uv_fault), .sdo(sdo), .fault_out_n_oe(fault_out_n_oe), .hv_out_a(hv_out_a),
   .hv_out_b(hv_out_b), .hv_out_c(hv_out_c), .hv_out_d(hv_out_d), .pump_on(pump_on),
   .analog_sleep(analog_sleep), .rail_uv_check_off(rail_uv_check_off),
   .switch_drive_reg(switch_drive_reg), .supervisory_ctrl_reg(supervisory_ctrl_reg),
   .port_mode(port_mode));
`default_nettype wire

// *** tb/switch_driver_control_port_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; $display("mismatch %s expected %h seen %h", what, exp, got); end end
module switch_driver_control_port_test;
   import switch_ctrl_pkg::*;
   logic sys_clk, rst_n, mode_select, polarity_strap, ctrl_in_1, ctrl_in_2, ctrl_in_3, trip;
   logic pump_enable_pin, fault_shutdown_pin, logic_uv_fault, rail_uv_fault;
   wire logic sck, sdi, port_select_n, sdo, sdo_oe, fault_out_n_oe, pump_on, analog_sleep;
   wire logic hv_out_a, hv_out_b, hv_out_c, hv_out_d, rail_uv_check_off;
   wire reg8_type switch_drive_reg, supervisory_ctrl_reg;
   wire port_mode_type port_mode;
   wire logic [3:0] hv = {hv_out_d, hv_out_c, hv_out_b, hv_out_a};
   // A released serial output shows the inverse of its last level
   wire logic sdo_pin = sdo_oe ? sdo : ~sdo;
   wire logic fault_drv;
   // Open-drain fault pin: pulled up while the design releases it
   wire logic fault_pin = fault_out_n_oe ? fault_drv : 1'b1;
   reg8_type cur_c, cur_d;
   frame_type shadow;
   logic [31:0] rx;
   int err_count, comparisons;
   switch_driver_control_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .mode_select(mode_select),
      .polarity_strap(polarity_strap), .sck(sck), .sdi(sdi), .port_select_n(port_select_n),
      .ctrl_in_1(ctrl_in_1), .ctrl_in_2(ctrl_in_2), .ctrl_in_3(ctrl_in_3),
      .pump_enable_pin(pump_enable_pin), .fault_shutdown_pin(fault_shutdown_pin),
      .logic_uv_fault(logic_uv_fault), .rail_uv_fault(rail_uv_fault), .sdo(sdo), .sdo_oe(sdo_oe),
      .fault_out_n_in(fault_pin), .fault_out_n_out(fault_drv), .fault_out_n_oe(fault_out_n_oe),
      .hv_out_a(hv_out_a), .hv_out_b(hv_out_b), .hv_out_c(hv_out_c), .hv_out_d(hv_out_d),
      .pump_on(pump_on), .analog_sleep(analog_sleep), .rail_uv_check_off(rail_uv_check_off),
      .switch_drive_reg(switch_drive_reg), .supervisory_ctrl_reg(supervisory_ctrl_reg),
      .port_mode(port_mode));
   host_model host (.sys_clk(sys_clk), .sdo(sdo_pin), .sck(sck), .sdi(sdi),
      .port_select_n(port_select_n));
   task automatic check_out();
      `CHECK("hv", trip ? 4'h0 : cur_d[3:0], hv)
      `CHECK("pump", cur_c[1] & ~cur_c[5] & ~trip, pump_on)
   endtask : check_out
   task automatic xfer(input frame_type tx, input int words = 1, input frame_type up = 16'h0);
      frame_type seen;
      host.frame({up, tx}, 16 * words, rx);
      seen = (words == 2) ? rx[31:16] : rx[15:0];
      `CHECK("readback", shadow, seen & 16'h7aff)
      if (words == 2) `CHECK("chain pass", up, rx[15:0])
      if (tx[15]) begin
         cur_c = {1'b0, cur_c[6] & tx[14], tx[13:8]};
         cur_d = tx[7:0];
      end
      trip = trip & cur_c[1];
      shadow = {1'b0, cur_c[6:0] & 7'h7a, cur_d};
      `CHECK("drive reg", cur_d, switch_drive_reg)
      `CHECK("ctrl reg", cur_c & 8'h7a, supervisory_ctrl_reg & 8'h7a)
      check_out();
   endtask : xfer
   task automatic wrap_up();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      #2000000;
      err_count++;
      wrap_up();
   end
   initial begin
      {rst_n, mode_select, polarity_strap, ctrl_in_1, ctrl_in_2, ctrl_in_3} = 6'h0;
      {pump_enable_pin, fault_shutdown_pin, logic_uv_fault, rail_uv_fault, trip} = 5'h0;
      {cur_c, cur_d, shadow} = 32'h0;
      err_count = 0;
      comparisons = 0;
      void'($urandom(51));
      host.wait_clk(20);
      rst_n = 1'b1;
      host.wait_clk(4);
      `CHECK("reset regs", 16'h0, {supervisory_ctrl_reg, switch_drive_reg})
      {mode_select, fault_shutdown_pin, pump_enable_pin} = 3'b111;
      for (int n = 0; n < 16; n++) begin
         {host.port_select_n, ctrl_in_3, ctrl_in_2, ctrl_in_1} = n[3:0];
         host.wait_clk(6);
         `CHECK("parallel hv", n[3:0], hv)
      end
      `CHECK("pump pin", 1'b1, pump_on)
      polarity_strap = 1'b1;
      host.wait_clk(6);
      `CHECK("strap hv", 4'h0, hv)
      {mode_select, polarity_strap} = 2'b00;
      host.wait_clk(6);
      `CHECK("mode", PORT_SERIAL, port_mode)
      for (int k = 0; k < 24; k++) begin
         {pump_enable_pin, fault_shutdown_pin, polarity_strap} = 3'($urandom);
         xfer({1'($urandom), 7'($urandom), 4'h0, 4'($urandom)},
              (k % 4 == 3) ? 2 : 1, 16'($urandom));
      end
      for (int m = 0; m < 2; m++) begin
         xfer(16'h8205 | 16'(m) << 12);
         logic_uv_fault = (m == 0) | 1'($urandom);
         rail_uv_fault = !logic_uv_fault | 1'($urandom);
         host.wait_clk(6);
         cur_c[6] = 1'b1;
         trip = (m == 0);
         `CHECK("fault state", 2'b01, {fault_pin, supervisory_ctrl_reg[6]})
         check_out();
         {rail_uv_fault, logic_uv_fault} = 2'b00;
         host.wait_clk(6);
         `CHECK("fault held", 2'b11, {fault_pin, supervisory_ctrl_reg[6]})
         check_out();
         xfer(16'h8005 | 16'(m) << 12);
         xfer(16'h8205 | 16'(m) << 12);
      end
      wrap_up();
   end
endmodule : switch_driver_control_port_test
`default_nettype wire
